// [hw/sacs_pkg.sv]
// constants and carrier types for the serial converter sequencer
// assumes one 40 MHz clock; conversion clocks arrive as enable pulses
package sacs_pkg;

    // ==========================================================
    // conversion timing, counted in conversion clocks
    localparam int unsigned RES_W        = 10;
    localparam int unsigned CNT_W        = 4;
    localparam logic [3:0]  CONV_FIRST   = 4'h1;
    localparam logic [3:0]  SAMPLE_CLOCK = 4'h3;
    localparam logic [3:0]  MSB_CLOCK    = 4'h4;
    localparam logic [3:0]  CONV_LAST    = 4'hE;
    localparam int unsigned FIFO_DEPTH   = 8;

    // ==========================================================
    // serial output pin: level and driver enable
    typedef struct packed {
        logic data;
        logic oe;
    } sacs_pin_t;

    localparam sacs_pin_t PIN_HIZ = '{data: 1'b0, oe: 1'b0};
    localparam sacs_pin_t PIN_LOW = '{data: 1'b0, oe: 1'b1};

    typedef enum logic {
        SACS_IDLE,
        SACS_CONV
    } sacs_state_t;

endpackage : sacs_pkg

// [hw/sacs_fifo.sv]
// sample buffer between the digitised input and the converter
// assumes a power-of-two depth; read data come out of a register
`timescale 1ns/1ps
`default_nettype none
module sacs_fifo
    import sacs_pkg::*;
#(
    parameter int unsigned WIDTH = RES_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      count_reg,  count_next;
    logic             ready_reg,  ready_next;
    logic             valid_reg,  valid_next;
    logic [WIDTH-1:0] data_reg,   data_next;
    logic             push;
    logic             pop;

    assign in_ready  = ready_reg;
    assign out_valid = valid_reg;
    assign out_data  = data_reg;

    // ==========================================================
    // pointers, fill count and head register
    always_comb
    begin
        push        = in_valid && ready_reg;
        pop         = out_ready && valid_reg;
        wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next  = (AW+1)'(count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        ready_next  = count_next != (AW+1)'(DEPTH);
        valid_next  = count_next != '0;
        // bypass when the new head is being written this cycle
        if (push && wr_ptr_reg == rd_ptr_next)
            data_next = in_data;
        else
            data_next = mem[rd_ptr_next];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b0;
            valid_reg  <= 1'b0;
            data_reg   <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            ready_reg  <= ready_next;
            valid_reg  <= valid_next;
            data_reg   <= data_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

endmodule : sacs_fifo
`default_nettype wire

// [hw/sacs_sequencer.sv]
// conversion sequencer and serial output of a 10-bit SAR converter
// assumes conv_tick marks each rising edge of the host conversion clock
// assumes the host keeps conv_tick running while a conversion is in progress
// assumes sample_data is a digitised input level in straight binary
// assumes sys_rst is held for at least one clk edge
// sdo_oe high means the serial pin is driven
//
// What this block does
// - start_conversion_n seen low: next rising edge is conversion clock one.
// - most significant bit appears after the fourth conversion clock.
// - every conversion lasts exactly fourteen conversion clocks.
// - start_conversion_n high at clock fourteen: tri-state output, go idle.
// - low again any time after clock fourteen starts next conversion next edge.
// - between synchronized conversions the output stays high impedance.
// - start_conversion_n held low: conversions follow back to back.
// - in free run the output is driven low between conversions.
// - two modes, no configuration; only start_conversion_n decides.
// - start_conversion_n going low launches conversion and enables driver.
// - serial output is three-state, timed by the conversion clock.
// - ten-bit successive approximation over clocks five to fourteen, MSB first.
// - output forced low from conversion start to first result bit.
// - result is straight unsigned binary.
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer
    import sacs_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // host side of the converter
    input  wire logic             conv_tick,
    input  wire logic             start_conversion_n,
    output logic                  sdo_data,
    output logic                  sdo_oe,
    // digitised analog input stream
    input  wire logic             sample_valid,
    output logic                  sample_ready,
    input  wire logic [RES_W-1:0] sample_data
);
    sacs_pin_t        pin_reg,    pin_next;
    sacs_state_t      state_reg,  state_next;
    logic [CNT_W-1:0] cnt_reg,    cnt_next;
    logic [RES_W-1:0] held_reg,   held_next;
    logic [RES_W-1:0] sar_reg,    sar_next;
    logic [CNT_W-1:0] cnt_inc;
    logic [RES_W-1:0] trial;
    logic             bit_keep;
    logic             idle_tick;
    logic             conv_step;
    logic             wrap_tick;
    logic             sample_tick;
    logic             bit_tick;
    logic             fifo_valid;
    logic             fifo_pop;
    logic [RES_W-1:0] fifo_data;

    // ==========================================================
    // sample buffer
    sacs_fifo #(
        .WIDTH (RES_W),
        .DEPTH (DEPTH)
    ) i_sacs_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // weight of the bit decided when the count reaches clk_no
    function automatic logic [RES_W-1:0] bit_weight(input logic [CNT_W-1:0] clk_no);
        logic [CNT_W-1:0] idx;
        idx        = CNT_W'(CONV_LAST - clk_no);
        bit_weight = RES_W'(1) << idx;
    endfunction : bit_weight

    assign sdo_data = pin_reg.data;
    assign sdo_oe   = pin_reg.oe;

    // ==========================================================
    // where the current conversion clock falls
    always_comb
    begin
        cnt_inc     = CNT_W'(cnt_reg + 1'b1);
        idle_tick   = conv_tick && state_reg == SACS_IDLE;
        conv_step   = conv_tick && state_reg == SACS_CONV;
        wrap_tick   = conv_step && cnt_reg == CONV_LAST;
        sample_tick = conv_step && cnt_inc == SAMPLE_CLOCK;
        bit_tick    = conv_step && cnt_reg != CONV_LAST && cnt_inc > MSB_CLOCK;
    end

    // ==========================================================
    // trial value for the bit decided at this clock
    always_comb
    begin
        trial    = sar_reg | bit_weight(cnt_inc);
        bit_keep = held_reg >= trial;
    end

    // ==========================================================
    // sequencing; mode follows only start_conversion_n
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (conv_tick)
        begin
            unique case (state_reg)
                SACS_IDLE:
                begin
                    if (!start_conversion_n)
                    begin
                        state_next = SACS_CONV;
                        cnt_next   = CONV_FIRST;
                    end
                end
                SACS_CONV:
                begin
                    if (cnt_reg != CONV_LAST)
                        cnt_next = cnt_inc;
                    else if (start_conversion_n)
                        state_next = SACS_IDLE;
                    else
                        cnt_next = CONV_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= SACS_IDLE;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ==========================================================
    // serial output pin; the LSB stands only until the next tick
    always_comb
    begin
        pin_next = pin_reg;
        if (idle_tick)
        begin
            if (start_conversion_n)
                pin_next = PIN_HIZ;
            else
                pin_next = PIN_LOW;
        end
        else if (wrap_tick)
        begin
            // free run keeps the pin driven low between conversions
            if (start_conversion_n)
                pin_next = PIN_HIZ;
            else
                pin_next = PIN_LOW;
        end
        else if (bit_tick)
        begin
            pin_next.oe   = 1'b1;
            pin_next.data = bit_keep;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pin_reg <= PIN_HIZ;
        else
            pin_reg <= pin_next;
    end

    // ==========================================================
    // sample hold and successive approximation register
    always_comb
    begin
        held_next = held_reg;
        sar_next  = sar_reg;
        fifo_pop  = sample_tick;
        if (sample_tick)
        begin
            // an empty buffer leaves the previous sample in place
            sar_next = '0;
            if (fifo_valid)
                held_next = fifo_data;
        end
        else if (bit_tick && bit_keep)
            sar_next = trial;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            held_reg <= '0;
            sar_reg  <= '0;
        end
        else
        begin
            held_reg <= held_next;
            sar_reg  <= sar_next;
        end
    end

endmodule : sacs_sequencer
`default_nettype wire

// [testbench/sacs_monitor.sv]
// pin-level assertions for the conversion sequencer
// assumes conv_tick pulses mark the host conversion clock edges
`timescale 1ns/1ps
`default_nettype none
module sacs_monitor
    import sacs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host side pins
    input wire logic conv_tick,
    input wire logic start_conversion_n,
    input wire logic sdo_data,
    input wire logic sdo_oe
);
    // ==========================================================
    // shadow conversion clock count
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    always_comb
    begin
        cnt_next = cnt_reg;
        if (conv_tick && (cnt_reg == 4'h0 || cnt_reg == CONV_LAST))
            cnt_next = start_conversion_n ? 4'h0 : CONV_FIRST;
        else if (conv_tick && cnt_reg != 4'h0)
            cnt_next = cnt_reg + 4'h1;
    end
    always_ff @(posedge clk)
        cnt_reg <= sys_rst ? 4'h0 : cnt_next;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence go_s;
        conv_tick && !start_conversion_n && cnt_reg == 4'h0;
    endsequence
    sequence wrap_s;
        conv_tick && cnt_reg == CONV_LAST;
    endsequence
    start_a: assert property (go_s |=> sdo_oe && !sdo_data)
        else $error("start did not drive low");
    run_a: assert property (go_s |=> (sdo_oe && !sdo_data)[*4])
        else $error("leading bits not low");
    low_a: assert property (cnt_reg != 4'h0 && cnt_reg <= MSB_CLOCK |-> !sdo_data)
        else $error("data before msb");
    drive_a: assert property (cnt_reg != 4'h0 |-> sdo_oe)
        else $error("driver off in conversion");
    hiz_a: assert property (cnt_reg == 4'h0 |-> !sdo_oe)
        else $error("driver on while idle");
    stand_a: assert property (!conv_tick |=> $stable(sdo_data) && $stable(sdo_oe))
        else $error("output moved without tick");
    free_a: assert property (wrap_s ##0 !start_conversion_n |=> sdo_oe && !sdo_data)
        else $error("free run gap not low");
    end_a: assert property (wrap_s ##0 start_conversion_n |=> !sdo_oe)
        else $error("single shot not released");
endmodule : sacs_monitor
bind sacs_sequencer sacs_monitor i_sacs_monitor (.clk(clk), .sys_rst(sys_rst),
    .conv_tick(conv_tick), .start_conversion_n(start_conversion_n),
    .sdo_data(sdo_data), .sdo_oe(sdo_oe));
`default_nettype wire

// [testbench/sacs_host_model.sv]
// host model: makes conversion clock ticks, drives start, captures words
// assumes gap of zero means the conversion clock is stopped
`timescale 1ns/1ps
`default_nettype none
module sacs_host_model
    import sacs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] gap,
    input wire logic run_n,
    input wire logic sdo_data,
    input wire logic sdo_oe,
    output logic conv_tick,
    output logic start_conversion_n,
    output logic [3:0] phase,
    output logic [RES_W-1:0] word,
    output logic word_stb
);
    logic [3:0] cnt = 4'h0;
    logic [RES_W-1:0] sh;
    logic cap = 1'b0;
    int t = 0;
    initial conv_tick = 1'b0;
    initial word_stb = 1'b0;
    assign start_conversion_n = run_n;
    assign phase = cnt;
    // ==========================================================
    // capture after each tick at count five or later, x when the driver is off
    always @(posedge clk)
    begin
        word_stb <= 1'b0;
        if (cap && cnt >= 4'h5)
            sh = {sh[RES_W-2:0], sdo_oe ? sdo_data : 1'bx};
        if (cap && cnt == CONV_LAST)
        begin
            word <= sh;
            word_stb <= 1'b1;
        end
        if (sys_rst)
            cnt = 4'h0;
        else if (conv_tick)
            cnt = (cnt == 4'h0 || cnt == CONV_LAST) ? 4'(!run_n) : cnt + 4'h1;
        cap = conv_tick;
        #2 conv_tick <= (gap != 3'h0) && (t == 0);
        t = (t >= int'(gap)) ? 0 : t + 1;
    end
endmodule : sacs_host_model
`default_nettype wire

// [testbench/sacs_sequencer_tb.sv]
// testbench for the conversion sequencer
// assumes the host model paces conversions and captures words
`timescale 1ns/1ps
`default_nettype none
module sacs_sequencer_tb;
    import sacs_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, run_n = 1'b1, sample_valid = 1'b0;
    logic [2:0] gap = 3'h1;
    logic [3:0] phase;
    logic [RES_W-1:0] sample_data = '0, word, d;
    logic conv_tick, start_conversion_n, sdo_data, sdo_oe, sample_ready, word_stb;
    logic [RES_W-1:0] exp_q[$];
    int err_total = 0, check_count = 0, seed = 32'h3B58, n_words = 0;
    always #12.5 clk = ~clk;
    sacs_sequencer i_sacs_sequencer (.clk(clk), .sys_rst(sys_rst), .conv_tick(conv_tick),
        .start_conversion_n(start_conversion_n), .sdo_data(sdo_data), .sdo_oe(sdo_oe),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data));
    sacs_host_model i_sacs_host_model (.clk(clk), .sys_rst(sys_rst), .gap(gap), .run_n(run_n),
        .sdo_data(sdo_data), .sdo_oe(sdo_oe), .conv_tick(conv_tick),
        .start_conversion_n(start_conversion_n), .phase(phase), .word(word),
        .word_stb(word_stb));
    // ==========================================================
    // report, sample push and wait helpers
    task conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task check(input logic [RES_W-1:0] got, input logic [RES_W-1:0] want);
        check_count++;
        if (got !== want)
        begin
            err_total++;
            $display("FAIL at %0t got %h want %h", $time, got, want);
        end
    endtask : check
    task push(input logic [RES_W-1:0] v);
        int i;
        i = 0;
        sample_valid = 1'b1;
        sample_data = v;
        exp_q.push_back(v);
        @(posedge clk);
        while (sample_ready !== 1'b1 && i < 500)
        begin
            i++;
            @(posedge clk);
        end
        if (i >= 500)
        begin
            err_total++;
            conclude();
        end
        #2;
    endtask : push
    task hold(input int w, input logic [3:0] p);
        int i;
        for (i = 0; i < 20000 && !(n_words >= w && phase === p); i++)
            @(posedge clk);
        if (i >= 20000)
        begin
            err_total++;
            conclude();
        end
        #2;
    endtask : hold
    // ==========================================================
    // result watcher takes the oldest note per captured word
    always @(posedge clk)
        if (word_stb === 1'b1)
        begin
            n_words++;
            check(word, exp_q.size() > 0 ? exp_q.pop_front() : ~word);
        end
    initial
    begin
        repeat (10) @(posedge clk);
        #2 sys_rst = 1'b0;
        for (int k = 0; k < FIFO_DEPTH; k++)
            push(10'($random(seed)));
        sample_valid = 1'b0;
        repeat (2) @(posedge clk);
        #2 check(10'(sample_ready), 10'h0);
        gap = 3'(1 + {$random(seed)} % 3);
        run_n = 1'b0;
        d = 10'($random(seed));
        push(d);
        sample_valid = 1'b0;
        exp_q.push_back(d);
        hold(9, 4'h8);
        run_n = 1'b1;
        hold(10, 4'h0);
        check(10'(sdo_oe), 10'h0);
        for (int k = 0; k < 3; k++)
        begin
            gap = 3'h0;
            repeat (20) @(posedge clk);
            #2 gap = 3'(k + 1);
            push(10'($random(seed)));
            sample_valid = 1'b0;
            repeat (30) @(posedge clk);
            #2 check(10'(sdo_oe), 10'h0);
            run_n = 1'b0;
            hold(10 + k, 4'h8);
            run_n = 1'b1;
            hold(11 + k, 4'h0);
        end
        check(10'(exp_q.size()), 10'h0);
        conclude();
    end
endmodule : sacs_sequencer_tb
`default_nettype wire
